// ### rtl/bmt_pkg.sv
package bmt_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MON      = 8'h0a; // battery_level_monitor
    localparam logic [7:0] ADDR_TMR      = 8'h0b; // input_guard_and_timer_ctrl
    localparam logic [7:0] RD_UNMAPPED   = 8'h00; // answer for other offsets
    localparam int         MON_START_BIT = 7;     // start_battery_reading
    localparam int         MON_BAND_HI   = 6;     // battery_band
    localparam int         MON_BAND_LO   = 5;
    localparam int         MON_STEP_HI   = 4;     // band_step
    localparam int         MON_STEP_LO   = 2;
    localparam int         TMR_OFF_BIT   = 7;     // input_sag_guard_disable
    localparam int         TMR_CODE_HI   = 6;     // input_sag_code
    localparam int         TMR_CODE_LO   = 4;
    localparam int         TMR_HALF_BIT  = 3;     // half_speed_timer
    localparam int         TMR_LIM_HI    = 2;     // safety_limit_select
    localparam int         TMR_LIM_LO    = 1;
    localparam int         TMR_RSV_BIT   = 0;     // unused
    localparam logic [7:0] TMR_RESET     = 8'h4a;
    // ------------------------------------------------------------
    // monitor codes
    // ------------------------------------------------------------
    localparam logic [1:0] BAND_TOP      = 2'h3;  // 90..100 %
    localparam logic [1:0] BAND_BOTTOM   = 2'h0;  // 60..70 %
    localparam logic [2:0] STEP_NONE     = 3'h0;
    // ------------------------------------------------------------
    // input sag guard and safety timer
    // ------------------------------------------------------------
    localparam logic [12:0] SAG_BASE_MV  = 13'h1068; // 4200 mV
    localparam logic [12:0] SAG_STEP_MV  = 13'h0064; // 100 mV
    localparam logic [12:0] SAG_RESET_MV = 13'h11f8; // 4600 mV
    localparam logic [1:0]  LIM_30MIN    = 2'h0;
    localparam logic [1:0]  LIM_3HR      = 2'h1;
    localparam logic [1:0]  LIM_9HR      = 2'h2;
    localparam logic [1:0]  LIM_OFF      = 2'h3;
    localparam logic [9:0]  MIN_30MIN    = 10'h01e;
    localparam logic [9:0]  MIN_3HR      = 10'h0b4;
    localparam logic [9:0]  MIN_9HR      = 10'h21c;
    localparam logic [9:0]  MIN_NONE     = 10'h000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         SYS_CLK_MHZ   = 125;
    localparam int         SETTLE_NS     = 400;   // comparator settling per band
    localparam int         SETTLE_CYC_I  = (SETTLE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SETTLE_CYC    = 8'(SETTLE_CYC_I);
    // ------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam int         BYTE_MSB      = 7;
    localparam int         RNW_BIT       = 0;
endpackage

// ### rtl/bmt_i2c_link.sv
`timescale 1ns/10ps
module bmt_i2c_link #(
    parameter logic [6:0] DEV_ADDR = 7'h2c
) (
    // link clock and frame reset
    input  wire logic       sclClk,
    input  wire logic       linkRst,
    // serial data pin
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // register pointer event
    output logic            ptrTog,
    output logic [7:0]      ptrByte,
    // register write event
    output logic            wrTog,
    output logic [7:0]      wrByte,
    // read data from system side
    input  wire logic [7:0] rdByte
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LK_SKIP, LK_DEV, LK_ACK_DEV, LK_PTR, LK_ACK_PTR,
        LK_WDAT, LK_ACK_WDAT, LK_RDAT, LK_RACK, LK_IGNORE
    } bmt_link_st_t;

    typedef struct packed {
        bmt_link_st_t st;      // byte phase
        logic [2:0]   bitCnt;  // bit inside byte
        logic [7:0]   shift;   // shift register
        logic         rnw;     // read request
        logic         oe;      // pulling data low
        logic         ptrTog;  // flips per pointer byte
        logic [7:0]   ptrByte; // last pointer
        logic         wrTog;   // flips per data byte
        logic [7:0]   wrByte;  // last data byte
    } bmt_link_t;

    bmt_link_t  q_r;
    bmt_link_t  q_nxt;
    logic [7:0] inByte;        // byte with current bit shifted in

    // ------------------------------------------------------------
    // byte engine; every edge is a falling clock edge, so data
    // sampled here is still valid and drive changes land while low
    // ------------------------------------------------------------
    always_comb begin
        q_nxt  = q_r;
        inByte = {q_r.shift[bmt_pkg::BYTE_MSB-1:0], sdaIn};
        unique case (q_r.st)
            // the first fall belongs to the start condition itself
            LK_SKIP: begin
                q_nxt.st     = LK_DEV;
                q_nxt.bitCnt = '0;
            end
            LK_DEV: begin
                if (q_r.bitCnt == bmt_pkg::BIT_LAST) begin
                    if (inByte[bmt_pkg::BYTE_MSB:1] == DEV_ADDR) begin
                        q_nxt.oe  = 1'b1;
                        q_nxt.rnw = inByte[bmt_pkg::RNW_BIT];
                        q_nxt.st  = LK_ACK_DEV;
                    end else begin
                        q_nxt.st = LK_IGNORE; // other target on the bus
                    end
                end else begin
                    q_nxt.shift  = inByte;
                    q_nxt.bitCnt = q_r.bitCnt + 3'h1;
                end
            end
            LK_ACK_DEV: begin
                q_nxt.bitCnt = '0;
                if (q_r.rnw) begin
                    q_nxt.shift = rdByte;
                    q_nxt.oe    = ~rdByte[bmt_pkg::BYTE_MSB];
                    q_nxt.st    = LK_RDAT;
                end else begin
                    q_nxt.oe = 1'b0;
                    q_nxt.st = LK_PTR;
                end
            end
            LK_PTR: begin
                if (q_r.bitCnt == bmt_pkg::BIT_LAST) begin
                    q_nxt.ptrByte = inByte;
                    q_nxt.ptrTog  = ~q_r.ptrTog;
                    q_nxt.oe      = 1'b1;
                    q_nxt.st      = LK_ACK_PTR;
                end else begin
                    q_nxt.shift  = inByte;
                    q_nxt.bitCnt = q_r.bitCnt + 3'h1;
                end
            end
            LK_ACK_PTR, LK_ACK_WDAT: begin
                q_nxt.oe     = 1'b0;
                q_nxt.bitCnt = '0;
                q_nxt.st     = LK_WDAT;
            end
            LK_WDAT: begin
                if (q_r.bitCnt == bmt_pkg::BIT_LAST) begin
                    q_nxt.wrByte = inByte;
                    q_nxt.wrTog  = ~q_r.wrTog;
                    q_nxt.oe     = 1'b1;
                    q_nxt.st     = LK_ACK_WDAT;
                end else begin
                    q_nxt.shift  = inByte;
                    q_nxt.bitCnt = q_r.bitCnt + 3'h1;
                end
            end
            LK_RDAT: begin
                if (q_r.bitCnt == bmt_pkg::BIT_LAST) begin
                    q_nxt.oe = 1'b0; // free the line for the host's answer
                    q_nxt.st = LK_RACK;
                end else begin
                    q_nxt.shift  = {q_r.shift[bmt_pkg::BYTE_MSB-1:0], 1'b0};
                    q_nxt.oe     = ~q_r.shift[bmt_pkg::BYTE_MSB-1];
                    q_nxt.bitCnt = q_r.bitCnt + 3'h1;
                end
            end
            LK_RACK: begin
                q_nxt.bitCnt = '0;
                if (!sdaIn) begin
                    // acknowledged: same register again
                    q_nxt.shift = rdByte;
                    q_nxt.oe    = ~rdByte[bmt_pkg::BYTE_MSB];
                    q_nxt.st    = LK_RDAT;
                end else begin
                    q_nxt.st = LK_IGNORE;
                end
            end
            LK_IGNORE: begin
                q_nxt.oe = 1'b0; // silent until the frame ends
            end
        endcase
    end

    // ------------------------------------------------------------
    // link registers, cleared by the system side at frame borders
    // ------------------------------------------------------------
    always_ff @(negedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sdaOut  = 1'b0;
    assign sdaOe   = q_r.oe;
    assign ptrTog  = q_r.ptrTog;
    assign ptrByte = q_r.ptrByte;
    assign wrTog   = q_r.wrTog;
    assign wrByte  = q_r.wrByte;
endmodule

// ### rtl/bmt_regs_top.sv
`timescale 1ns/10ps
module bmt_regs_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2c // arbitrary target address
) (
    // system clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // serial link
    input  wire logic       sclClk,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // battery comparator
    input  wire logic       lowPowerReq,
    input  wire logic [2:0] bandStepIn,
    output logic [1:0]      trialBand,
    output logic            measBusy,
    output logic            monitorDone,
    output logic [1:0]      batteryBand,
    output logic [2:0]      bandStep,
    // charger state
    input  wire logic       chargeInCc,
    input  wire logic       chargeInCv,
    // guard and timer controls
    output logic            inputSagGuardEn,
    output logic [2:0]      inputSagCode,
    output logic [12:0]     inputSagThreshMv,
    output logic            safetyTimerHalfRate,
    output logic [1:0]      safetyLimitSelect,
    output logic [9:0]      safetyLimitMin,
    output logic            safetyTimerOff
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic {SEQ_IDLE, SEQ_SETTLE} bmt_seq_st_t;

    typedef struct packed {
        logic        sclS1;     // link clock level, first stage
        logic        sclS2;     // link clock level, second stage
        logic        sclD;      // previous second stage
        logic        sdaS1;     // data level, first stage
        logic        sdaS2;     // data level, second stage
        logic        sdaD;      // previous second stage
        logic        linkRst;   // holds the link side cleared
        logic        inFrame;   // between start and stop
        logic        ptrS1;     // pointer toggle crossing
        logic        ptrS2;
        logic        ptrD;
        logic        wrS1;      // write toggle crossing
        logic        wrS2;
        logic        wrD;
        logic [7:0]  regPtr;    // register pointer copy
        logic [7:0]  rdByte;    // word offered to the link
        logic [2:0]  stepS1;    // comparator step, first stage
        logic [2:0]  stepS2;    // comparator step, second stage
        bmt_seq_st_t seqSt;     // search sequencer
        logic [1:0]  trial;     // band under test
        logic [7:0]  settleCnt; // settling countdown
        logic [1:0]  monBand;   // stored band
        logic [2:0]  monStep;   // stored step
        logic        done;      // search finished pulse
        logic [7:0]  tmrReg;    // guard and timer register
        logic [12:0] sagMv;     // guard threshold in mV
        logic        halfRate;  // timer runs slow
        logic [9:0]  limitMin;  // fast charge limit
    } bmt_sys_t;

    bmt_sys_t   q_r;
    bmt_sys_t   q_nxt;

    // link side wires
    logic       linkPtrTog;     // pointer toggle from link
    logic [7:0] linkPtrByte;    // pointer value, stable after toggle
    logic       linkWrTog;      // write toggle from link
    logic [7:0] linkWrByte;     // write value, stable after toggle

    // ------------------------------------------------------------
    // link clock domain
    // ------------------------------------------------------------
    bmt_i2c_link #(
        .DEV_ADDR (DEV_ADDR)
    ) u_link (
        .sclClk   (sclClk),
        .linkRst  (q_r.linkRst),
        .sdaIn    (sdaIn),
        .sdaOut   (sdaOut),
        .sdaOe    (sdaOe),
        .ptrTog   (linkPtrTog),
        .ptrByte  (linkPtrByte),
        .wrTog    (linkWrTog),
        .wrByte   (linkWrByte),
        .rdByte   (q_r.rdByte)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic       startSeen;      // data falls while clock high
    logic       stopSeen;       // data rises while clock high
    logic       ptrEv;          // new pointer arrived
    logic       wrEv;           // new data byte arrived
    logic       startMeas;      // launch a search
    logic [7:0] rdSel;          // pointer used for read word
    logic [7:0] monWord;        // monitor register image

    always_comb begin
        q_nxt      = q_r;
        q_nxt.done = 1'b0;

        // scl, sda and step levels pass two stages before the logic here looks at them
        q_nxt.sclS1  = sclClk;
        q_nxt.sclS2  = q_r.sclS1;
        q_nxt.sclD   = q_r.sclS2;
        q_nxt.sdaS1  = sdaIn;
        q_nxt.sdaS2  = q_r.sdaS1;
        q_nxt.sdaD   = q_r.sdaS2;
        q_nxt.stepS1 = bandStepIn;
        q_nxt.stepS2 = q_r.stepS1;

        startSeen = q_r.sclS2 & q_r.sclD & q_r.sdaD & ~q_r.sdaS2;
        stopSeen  = q_r.sclS2 & q_r.sclD & ~q_r.sdaD & q_r.sdaS2;

        // frame borders: the link clock stops outside frames, so the
        // link side is ended from here rather than by its own edges
        if (q_r.linkRst && q_r.inFrame) begin
            q_nxt.linkRst = 1'b0;     // end of a repeated-start pulse
        end
        if (startSeen) begin
            q_nxt.linkRst = q_r.inFrame;
            q_nxt.inFrame = 1'b1;
        end
        if (stopSeen) begin
            q_nxt.linkRst = 1'b1;
            q_nxt.inFrame = 1'b0;
        end

        // toggle crossings; both ends clear together at frame borders
        if (q_r.linkRst) begin
            q_nxt.ptrS1 = 1'b0;
            q_nxt.ptrS2 = 1'b0;
            q_nxt.ptrD  = 1'b0;
            q_nxt.wrS1  = 1'b0;
            q_nxt.wrS2  = 1'b0;
            q_nxt.wrD   = 1'b0;
        end else begin
            q_nxt.ptrS1 = linkPtrTog;
            q_nxt.ptrS2 = q_r.ptrS1;
            q_nxt.ptrD  = q_r.ptrS2;
            q_nxt.wrS1  = linkWrTog;
            q_nxt.wrS2  = q_r.wrS1;
            q_nxt.wrD   = q_r.wrS2;
        end
        ptrEv = q_r.ptrS2 ^ q_r.ptrD;
        wrEv  = q_r.wrS2 ^ q_r.wrD;

        if (ptrEv) begin
            q_nxt.regPtr = linkPtrByte;
        end

        // register writes
        startMeas = lowPowerReq;
        if (wrEv) begin
            if (q_r.regPtr == bmt_pkg::ADDR_MON) begin
                // only the start bit acts; the rest is status
                if (linkWrByte[bmt_pkg::MON_START_BIT]) begin
                    startMeas = 1'b1;
                end
            end else if (q_r.regPtr == bmt_pkg::ADDR_TMR) begin
                q_nxt.tmrReg = linkWrByte;
                q_nxt.tmrReg[bmt_pkg::TMR_RSV_BIT] = 1'b0;
            end
        end

        // descending band search
        unique case (q_r.seqSt)
            SEQ_IDLE: begin
                q_nxt.seqSt = SEQ_IDLE;
            end
            SEQ_SETTLE: begin
                if (q_r.settleCnt != 8'h00) begin
                    q_nxt.settleCnt = q_r.settleCnt - 8'h01;
                end else if (q_r.stepS2 != bmt_pkg::STEP_NONE) begin
                    // first band with a nonzero step wins
                    q_nxt.monBand = q_r.trial;
                    q_nxt.monStep = q_r.stepS2;
                    q_nxt.done    = 1'b1;
                    q_nxt.seqSt   = SEQ_IDLE;
                end else if (q_r.trial == bmt_pkg::BAND_BOTTOM) begin
                    q_nxt.monBand = bmt_pkg::BAND_BOTTOM;
                    q_nxt.monStep = bmt_pkg::STEP_NONE;
                    q_nxt.done    = 1'b1;
                    q_nxt.seqSt   = SEQ_IDLE;
                end else begin
                    q_nxt.trial     = q_r.trial - 2'h1;
                    q_nxt.settleCnt = bmt_pkg::SETTLE_CYC - 8'h01;
                end
            end
        endcase
        // a new launch restarts from the top even mid-search
        if (startMeas) begin
            q_nxt.seqSt     = SEQ_SETTLE;
            q_nxt.trial     = bmt_pkg::BAND_TOP;
            q_nxt.settleCnt = bmt_pkg::SETTLE_CYC - 8'h01;
        end

        // read word: refreshed only when the link cannot be sampling
        // it, which keeps the word steady while bits are shifted out
        monWord = '0;
        monWord[bmt_pkg::MON_BAND_HI:bmt_pkg::MON_BAND_LO] = q_nxt.monBand;
        monWord[bmt_pkg::MON_STEP_HI:bmt_pkg::MON_STEP_LO] = q_nxt.monStep;
        rdSel = ptrEv ? linkPtrByte : q_r.regPtr;
        if (ptrEv || q_r.linkRst) begin
            if (rdSel == bmt_pkg::ADDR_MON) begin
                q_nxt.rdByte = monWord;
            end else if (rdSel == bmt_pkg::ADDR_TMR) begin
                q_nxt.rdByte = q_nxt.tmrReg;
            end else begin
                q_nxt.rdByte = bmt_pkg::RD_UNMAPPED;
            end
        end

        // guard threshold follows the code at once
        q_nxt.sagMv = bmt_pkg::SAG_BASE_MV + 13'(13'(q_nxt.tmrReg[bmt_pkg::TMR_CODE_HI:bmt_pkg::TMR_CODE_LO])
                      * bmt_pkg::SAG_STEP_MV);

        // slow timer only outside constant current and voltage
        q_nxt.halfRate = q_r.tmrReg[bmt_pkg::TMR_HALF_BIT] & ~(chargeInCc | chargeInCv);

        // fast charge limit
        unique case (q_nxt.tmrReg[bmt_pkg::TMR_LIM_HI:bmt_pkg::TMR_LIM_LO])
            bmt_pkg::LIM_30MIN: q_nxt.limitMin = bmt_pkg::MIN_30MIN;
            bmt_pkg::LIM_3HR:   q_nxt.limitMin = bmt_pkg::MIN_3HR;
            bmt_pkg::LIM_9HR:   q_nxt.limitMin = bmt_pkg::MIN_9HR;
            bmt_pkg::LIM_OFF:   q_nxt.limitMin = bmt_pkg::MIN_NONE;
        endcase
    end

    // ------------------------------------------------------------
    // registers; the tmrReg default stands until the host writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q_r          <= '0;
            q_r.linkRst  <= 1'b1;               // link idle until start
            q_r.tmrReg   <= bmt_pkg::TMR_RESET;
            q_r.sagMv    <= bmt_pkg::SAG_RESET_MV;
            q_r.limitMin <= bmt_pkg::MIN_3HR;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign trialBand           = q_r.trial;
    assign measBusy            = (q_r.seqSt == SEQ_SETTLE);
    assign monitorDone         = q_r.done;
    assign batteryBand         = q_r.monBand;
    assign bandStep            = q_r.monStep;
    assign inputSagGuardEn     = ~q_r.tmrReg[bmt_pkg::TMR_OFF_BIT];
    assign inputSagCode        = q_r.tmrReg[bmt_pkg::TMR_CODE_HI:bmt_pkg::TMR_CODE_LO];
    assign inputSagThreshMv    = q_r.sagMv;
    assign safetyTimerHalfRate = q_r.halfRate;
    assign safetyLimitSelect   = q_r.tmrReg[bmt_pkg::TMR_LIM_HI:bmt_pkg::TMR_LIM_LO];
    assign safetyLimitMin      = q_r.limitMin;
    assign safetyTimerOff      = (q_r.tmrReg[bmt_pkg::TMR_LIM_HI:bmt_pkg::TMR_LIM_LO] == bmt_pkg::LIM_OFF);
endmodule

// ### verification/bmt_regs_sva.sv
`timescale 1ns/10ps
// watches control outputs and the battery search sequencer
module bmt_regs_sva (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // charger state and search
    input wire logic        chargeInCc,
    input wire logic        chargeInCv,
    input wire logic [1:0]  trialBand,
    input wire logic        measBusy,
    input wire logic        monitorDone,
    // guard and timer controls
    input wire logic [2:0]  inputSagCode,
    input wire logic [12:0] inputSagThreshMv,
    input wire logic        safetyTimerHalfRate,
    input wire logic [1:0]  safetyLimitSelect,
    input wire logic [9:0]  safetyLimitMin,
    input wire logic        safetyTimerOff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_sag_thresh: assert property (inputSagThreshMv == 13'h1068 + 13'h0064 * inputSagCode)
        else $error("sag threshold wrong");
    a_limit_min: assert property (safetyLimitMin == (safetyLimitSelect == 2'h0 ? 10'h01e :
        safetyLimitSelect == 2'h1 ? 10'h0b4 : safetyLimitSelect == 2'h2 ? 10'h21c : 10'h000)) else $error("limit");
    a_timer_off: assert property (safetyTimerOff == (safetyLimitSelect == 2'h3)) else $error("timer off");
    // cc or cv must stop the half rate one cycle later
    a_half_rate: assert property ((chargeInCc || chargeInCv) |=> !safetyTimerHalfRate)
        else $error("half rate in cc/cv");
    a_search_top: assert property ($rose(measBusy) |-> trialBand == 2'h3) else $error("search start");
    a_band_descend: assert property ($changed(trialBand) && measBusy && trialBand != 2'h3
        |-> trialBand == $past(trialBand) - 2'h1) else $error("band order");
    a_search_bound: assert property ($rose(measBusy) |-> ##[50:215] monitorDone) else $error("search time");
    a_done_idle: assert property (monitorDone |-> !measBusy) else $error("done while busy");
endmodule
bind bmt_regs_top bmt_regs_sva u_sva (.sys_clk(sys_clk), .rst(rst), .chargeInCc(chargeInCc),
    .chargeInCv(chargeInCv), .trialBand(trialBand), .measBusy(measBusy), .monitorDone(monitorDone),
    .inputSagCode(inputSagCode), .inputSagThreshMv(inputSagThreshMv), .safetyTimerHalfRate(safetyTimerHalfRate),
    .safetyLimitSelect(safetyLimitSelect), .safetyLimitMin(safetyLimitMin), .safetyTimerOff(safetyTimerOff));

// ### verification/bmt_i2c_host.sv
`timescale 1ns/10ps
// i2c host: 64 ns scl, idle high; sda open drain with pull-up
module bmt_i2c_host #(
    parameter logic [6:0] DEV = 7'h2c // arbitrary, matches the device
) (
    // bus wires
    output logic      scl,
    output logic      sdaWire,
    // device pull-down enable
    input wire logic  devOe
);
    logic       hostSda; // low while host pulls sda
    logic [2:0] ackLog;  // last three ninth bits, 0 = acked
    // pull-up wins unless a party pulls low
    assign sdaWire = hostSda & ~devOe;
    initial begin
        scl = 1'b1;
        hostSda = 1'b1;
        ackLog = 3'h0;
    end
    // data set while scl low, sampled mid-high
    task automatic bitx(input logic b, output logic s);
        hostSda = b;
        #16 scl = 1'b1;
        #16 s = sdaWire;
        #16 scl = 1'b0;
        #16;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx);
        logic a;
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
        bitx(ackIn, a);
        ackLog = {ackLog[1:0], a};
    endtask
    // odd offset keeps scl edges off the system clock edges
    task automatic start();
        #1.3 hostSda = 1'b1;
        #16 scl = 1'b1;
        #16 hostSda = 1'b0;
        #48 scl = 1'b0;
        #16;
    endtask
    task automatic stop();
        hostSda = 1'b0;
        #16 scl = 1'b1;
        #16 hostSda = 1'b1;
        #32;
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] d, input logic [6:0] da);
        logic [7:0] r;
        start();
        xfer({da, 1'b0}, 1'b1, r);
        xfer(ra, 1'b1, r);
        xfer(d, 1'b1, r);
        stop();
    endtask
    // pointer write, repeated start, one byte then nack
    task automatic rd(input logic [7:0] ra, output logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({DEV, 1'b0}, 1'b1, r);
        xfer(ra, 1'b1, r);
        start();
        xfer({DEV, 1'b1}, 1'b1, r);
        xfer(8'hff, 1'b1, d);
        stop();
    endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, lpReq = 1'b0, cc = 1'b0, cv = 1'b0, scl, sda, oe, busy, done;
    logic        guardEn, half, tOff, so;
    logic [1:0]  trial, band, lim, tBand = 2'h0;
    logic [2:0]  step, code, tStep = 3'h0, stepIn;
    logic [12:0] thr;
    logic [9:0]  limMin;
    logic [7:0]  d;
    logic [1:0]  bands [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h0};
    logic [2:0]  steps [6] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
    int          errorCnt = 0, nTests = 0, cyc = 0, n;
    // comparator stand-in: nonzero step only in the chosen band
    assign stepIn = (trial === tBand) ? tStep : 3'h0;
    always #4 clk = ~clk;
    bmt_regs_top u_dut (.sys_clk(clk), .rst(rst), .sclClk(scl), .sdaIn(sda), .sdaOut(so), .sdaOe(oe),
        .lowPowerReq(lpReq), .bandStepIn(stepIn), .trialBand(trial), .measBusy(busy), .monitorDone(done),
        .batteryBand(band), .bandStep(step), .chargeInCc(cc), .chargeInCv(cv), .inputSagGuardEn(guardEn),
        .inputSagCode(code), .inputSagThreshMv(thr), .safetyTimerHalfRate(half), .safetyLimitSelect(lim),
        .safetyLimitMin(limMin), .safetyTimerOff(tOff));
    bmt_i2c_host u_host (.scl(scl), .sdaWire(sda), .devOe(oe));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdChk(input string nm, input logic [7:0] ra, input logic [7:0] exp);
        logic [7:0] r;
        u_host.rd(ra, r);
        check(nm, 32'(r), 32'(exp));
    endtask
    function automatic logic [9:0] minOf(input logic [1:0] s);
        return s == 2'h0 ? 10'h01e : s == 2'h1 ? 10'h0b4 : s == 2'h2 ? 10'h21c : 10'h000;
    endfunction
    task automatic summarize();
        if (errorCnt == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errorCnt++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        check("rstCtl", {guardEn, code, half, lim, tOff, thr, limMin}, {8'hca, 13'h11f8, 10'h0b4});
        rdChk("rstTmr", 8'h0b, 8'h4a);
        rdChk("rstMon", 8'h0a, 8'h00);
        rdChk("unmapped", 8'h05, 8'h00);
        // every code, limit and disable setting, with cc/cv varied
        for (int i = 0; i < 8; i++) begin
            d = {i[0], i[2:0], i[1], i[2:1], 1'b1};
            @(negedge clk);
            cc = i[2] & ~i[0];
            cv = i[2] & i[0];
            u_host.wr(8'h0b, d, 7'h2c);
            check("ack", 32'({so, u_host.ackLog}), 32'h0);
            repeat (4) @(negedge clk);
            check("ctl", {~d[7], d[6:4], d[2:1], d[2:1] == 2'h3, d[3] & ~(cc | cv)},
                {guardEn, code, lim, tOff, half});
            check("thrMin", {thr, limMin}, {13'h1068 + 13'h0064 * d[6:4], minOf(d[2:1])});
            rdChk("tmrRd", 8'h0b, d & 8'hfe);
        end
        u_host.wr(8'h0b, 8'h00, 7'h2d);
        check("nack", 32'(u_host.ackLog), 32'h7);
        rdChk("kept", 8'h0b, 8'hfe);
        // searches launched by request pin and by register write
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            tBand = bands[k];
            tStep = steps[k];
            if (k[0]) begin
                u_host.wr(8'h0a, 8'h80, 7'h2c);
            end else begin
                lpReq = 1'b1;
                @(negedge clk) lpReq = 1'b0;
                @(negedge clk);
                check("launch", {busy, trial}, 3'h7);
            end
            n = 0;
            while (done !== 1'b1 && n < 300) begin
                @(negedge clk);
                n++;
            end
            check("result", {done, band, step}, {1'b1, tBand, tStep});
            rdChk("monRd", 8'h0a, {1'b0, tBand, tStep, 2'h0});
        end
        summarize();
    end
endmodule
